//--- hdl/srs_pkg.sv
// Constants for the receiver status readout block
// Assumes a 16-bit register read port with byte-wide addresses
// Summary of operation
// [RL1] Mute status reads 1 once mute completed
// [RL2] Source status bit shows selected input pin
// [RL3] Burst flag set while burst preambles seen
// [RL4] Bit error flag shows bi-phase errors
// [RL5] Lock flag shows decoder lock state
// [RL6] Left status bits 15..0 same index
// [RL7] Left status bits 31..16 in bits 15..0
// [RL8] Left status bits 39..32 in low byte
// [RL9] Right status bits 15..0 same index
// [RL10] Right status bits 31..16 in bits 15..0
// [RL11] Right status bits 39..32 in low byte
// [RL12] Capture 40 status bits per channel
// [RL13] Select bit picks input pin, default zero
// [RL14] Merge control folds PCM detect into lock
// [RL15] Burst auto-mute enable mutes on bursts
// [RL16] Reserved bits read zero, reads harmless
// [RL17] Status sets update only on whole blocks
package srs_pkg;
	localparam int          DATA_W          = 16;
	localparam int          ADDR_W          = 8;
	localparam int          CS_BITS         = 40;
	localparam logic [7:0]  ADDR_MUTE_STAT  = 8'h18;
	localparam logic [7:0]  ADDR_RX_STAT    = 8'h59;
	localparam logic [7:0]  ADDR_LEFT_LOW   = 8'h5A;
	localparam logic [7:0]  ADDR_LEFT_MID   = 8'h5B;
	localparam logic [7:0]  ADDR_LEFT_HIGH  = 8'h5C;
	localparam logic [7:0]  ADDR_RIGHT_LOW  = 8'h5D;
	localparam logic [7:0]  ADDR_RIGHT_MID  = 8'h5E;
	localparam logic [7:0]  ADDR_RIGHT_HIGH = 8'h5F;
	localparam int          POS_MUTE        = 2;
	localparam int          POS_SOURCE      = 3;
	localparam int          POS_BURST       = 2;
	localparam int          POS_BERR        = 1;
	localparam int          POS_LOCK        = 0;
	localparam logic        RST_SELECT      = 1'b0;
	localparam logic        RST_MERGE       = 1'b1;
	localparam logic        RST_AUTOMUTE    = 1'b1;
	localparam logic [15:0] RST_REG         = 16'h0000;
	localparam int          MUTE_STEPS      = 16;
endpackage

//--- hdl/srs_cs_capture.sv
// One channel's status block assembler
// Assumes one status bit per frame, with a block-start marker
`timescale 1ns/1ps
`default_nettype none
module srs_cs_capture
(
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	input  wire logic                        bitValid,
	input  wire logic                        bitValue,
	input  wire logic                        blockStart,
	output var  logic [srs_pkg::CS_BITS-1:0] held
);
	logic [srs_pkg::CS_BITS-1:0] shadow;
	logic [5:0]                  count;

	// ----------------------------------------
	// Store bits by index, publish on the 40th
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shadow <= '0;
			count  <= 6'h00;
			held   <= '0;
		end
		else if (bitValid)
		begin
			if (blockStart)
				shadow[0] <= bitValue; // [RL12]
			else if (count < 6'(srs_pkg::CS_BITS))
				shadow[count] <= bitValue; // [RL12]
			if (blockStart)
				count <= 6'h01;
			else if (count < 6'(srs_pkg::CS_BITS))
				count <= count + 6'h01;
			if (!blockStart && count == 6'(srs_pkg::CS_BITS - 1))
				held <= {bitValue, shadow[srs_pkg::CS_BITS-2:0]}; // [RL17]
		end
	end

	AST_WHOLE_BLOCK: assert property (@(posedge clk) disable iff (!rst_n)
		(held != $past(held)) |-> $past(bitValid && !blockStart && count == 6'(srs_pkg::CS_BITS - 1))) // [RL17]
		else $error("status set changed before a full block");
endmodule
`default_nettype wire

//--- hdl/srs_status_readout.sv
// Receiver status readout registers and mute sequencing
// Assumes decoder flags and status bits arrive synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module srs_status_readout
#(
	parameter int MUTE_STEPS = srs_pkg::MUTE_STEPS
)
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        inputSourceSelect,
	input  wire logic        burstAutoMuteEnable,
	input  wire logic        pcmLockMerge,
	input  wire logic        hostMuteRequest,
	input  wire logic        decoderLock,
	input  wire logic        pcmDetect,
	input  wire logic        burstSeen,
	input  wire logic        biphaseError,
	input  wire logic        leftBitValid,
	input  wire logic        rightBitValid,
	input  wire logic        chanStatusBit,
	input  wire logic        blockStart,
	input  wire logic        readStrobe,
	input  wire logic [7:0]  readAddr,
	output logic      [15:0] readData,
	output logic             readValid,
	output logic             audioMuted,
	output logic             activeInput
);
	logic [39:0] leftStatus;
	logic [39:0] rightStatus;
	logic        muteStateFlag;
	logic        burstSeenFlag;
	logic        bitErrorFlag;
	logic        receiverLockFlag;
	logic        inputSourceFlag;
	logic [7:0]  muteCount;
	logic [15:0] next_readData;

	// ----------------------------------------
	// Channel status capture
	// ----------------------------------------
	srs_cs_capture leftCapture
	(
		.clk        (clk),
		.rst_n      (rst_n),
		.bitValid   (leftBitValid),
		.bitValue   (chanStatusBit),
		.blockStart (blockStart),
		.held       (leftStatus)
	);

	srs_cs_capture rightCapture
	(
		.clk        (clk),
		.rst_n      (rst_n),
		.bitValid   (rightBitValid),
		.bitValue   (chanStatusBit),
		.blockStart (blockStart),
		.held       (rightStatus)
	);

	// ----------------------------------------
	// Receiver flags and source selection
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			burstSeenFlag    <= 1'b0;
			bitErrorFlag     <= 1'b0;
			receiverLockFlag <= 1'b0;
			inputSourceFlag  <= srs_pkg::RST_SELECT;
			activeInput      <= srs_pkg::RST_SELECT;
		end
		else
		begin
			burstSeenFlag    <= burstSeen; // [RL3]
			bitErrorFlag     <= biphaseError; // [RL4]
			receiverLockFlag <= decoderLock & (pcmDetect | ~pcmLockMerge); // [RL5] [RL14]
			inputSourceFlag  <= inputSourceSelect; // [RL2]
			activeInput      <= inputSourceSelect; // [RL13]
		end
	end

	// ----------------------------------------
	// Mute sequence: ramp count, then muted
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			muteCount     <= 8'h00;
			muteStateFlag <= 1'b0;
			audioMuted    <= 1'b0;
		end
		else if (hostMuteRequest || (burstAutoMuteEnable && burstSeenFlag)) // [RL15]
		begin
			if (muteCount < 8'(MUTE_STEPS))
				muteCount <= muteCount + 8'h01;
			muteStateFlag <= (muteCount >= 8'(MUTE_STEPS - 1)); // [RL1]
			audioMuted    <= (muteCount >= 8'(MUTE_STEPS - 1));
		end
		else
		begin
			muteCount     <= 8'h00;
			muteStateFlag <= 1'b0; // [RL1]
			audioMuted    <= 1'b0;
		end
	end

	// ----------------------------------------
	// Read decode, reserved bits zero
	// ----------------------------------------
	always_comb
	begin
		next_readData = srs_pkg::RST_REG; // [RL16]
		unique case (readAddr)
			srs_pkg::ADDR_MUTE_STAT:  next_readData[srs_pkg::POS_MUTE] = muteStateFlag; // [RL1]
			srs_pkg::ADDR_RX_STAT:
			begin
				next_readData[srs_pkg::POS_SOURCE] = inputSourceFlag; // [RL2]
				next_readData[srs_pkg::POS_BURST]  = burstSeenFlag; // [RL3]
				next_readData[srs_pkg::POS_BERR]   = bitErrorFlag; // [RL4]
				next_readData[srs_pkg::POS_LOCK]   = receiverLockFlag; // [RL5]
			end
			srs_pkg::ADDR_LEFT_LOW:   next_readData = leftStatus[15:0]; // [RL6]
			srs_pkg::ADDR_LEFT_MID:   next_readData = leftStatus[31:16]; // [RL7]
			srs_pkg::ADDR_LEFT_HIGH:  next_readData[7:0] = leftStatus[39:32]; // [RL8]
			srs_pkg::ADDR_RIGHT_LOW:  next_readData = rightStatus[15:0]; // [RL9]
			srs_pkg::ADDR_RIGHT_MID:  next_readData = rightStatus[31:16]; // [RL10]
			srs_pkg::ADDR_RIGHT_HIGH: next_readData[7:0] = rightStatus[39:32]; // [RL11]
			default:                  next_readData = srs_pkg::RST_REG;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			readData  <= srs_pkg::RST_REG;
			readValid <= 1'b0;
		end
		else
		begin
			readValid <= readStrobe;
			if (readStrobe)
				readData <= next_readData;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_MUTE_ONLY_AFTER_RAMP: assert property (@(posedge clk) disable iff (!rst_n)
		muteStateFlag |-> $past(muteCount) >= 8'(MUTE_STEPS - 1)) // [RL1]
		else $error("mute status set before ramp finished");
	AST_SOURCE_READ: assert property (@(posedge clk) disable iff (!rst_n)
		readStrobe && readAddr == 8'h59 |=> readData[3] == $past(inputSourceFlag)) // [RL2]
		else $error("source bit read wrong");
	AST_BURST_FOLLOW: assert property (@(posedge clk) disable iff (!rst_n)
		burstSeen |=> burstSeenFlag) // [RL3]
		else $error("burst flag missed");
	AST_BERR_FOLLOW: assert property (@(posedge clk) disable iff (!rst_n)
		biphaseError != 1'b0 ##1 1'b1 |-> bitErrorFlag) // [RL4]
		else $error("bit error flag missed");
	AST_LOCK_MERGE: assert property (@(posedge clk) disable iff (!rst_n)
		decoderLock && pcmLockMerge && !pcmDetect |=> !receiverLockFlag) // [RL5]
		else $error("lock set without PCM detect");
	AST_LEFT_MID: assert property (@(posedge clk) disable iff (!rst_n)
		readStrobe && readAddr == 8'h5B |=> readData == $past(leftStatus[31:16])) // [RL7]
		else $error("left mid read wrong");
	AST_RIGHT_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
		readStrobe && readAddr == 8'h5F |=> readData == {8'h00, $past(rightStatus[39:32])}) // [RL11]
		else $error("right high read wrong");
	AST_NO_BURST_MUTE: assert property (@(posedge clk) disable iff (!rst_n)
		!hostMuteRequest && !burstAutoMuteEnable |=> !muteStateFlag) // [RL15]
		else $error("muted with auto-mute off");
	AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
		readStrobe && readAddr == 8'h59 |=> readData[15:4] == 12'h000) // [RL16]
		else $error("reserved bits nonzero");
	AST_LEFT_LOW: assert property (@(posedge clk) disable iff (!rst_n) // [RL6]
		readStrobe && readAddr == srs_pkg::ADDR_LEFT_LOW |=> readData == $past(leftStatus[15:0]))
		else $error("left low read wrong");
	AST_LEFT_HIGH: assert property (@(posedge clk) disable iff (!rst_n) // [RL8]
		readStrobe && readAddr == srs_pkg::ADDR_LEFT_HIGH |=> readData == {8'h00, $past(leftStatus[39:32])})
		else $error("left high read wrong");
	AST_RIGHT_LOW: assert property (@(posedge clk) disable iff (!rst_n) // [RL9]
		readStrobe && readAddr == srs_pkg::ADDR_RIGHT_LOW |=> readData == $past(rightStatus[15:0]))
		else $error("right low read wrong");
	AST_RIGHT_MID: assert property (@(posedge clk) disable iff (!rst_n) // [RL10]
		readStrobe && readAddr == srs_pkg::ADDR_RIGHT_MID |=> readData == $past(rightStatus[31:16]))
		else $error("right mid read wrong");
	AST_SOURCE_FOLLOW: assert property (@(posedge clk) disable iff (!rst_n) // [RL13]
		1'b1 |=> activeInput == $past(inputSourceSelect))
		else $error("active input does not follow select");
	AST_LOCK_NO_MERGE: assert property (@(posedge clk) disable iff (!rst_n) // [RL14]
		!pcmLockMerge |=> receiverLockFlag == $past(decoderLock))
		else $error("lock flag wrong with merge off");
	AST_MUTE_RESERVED: assert property (@(posedge clk) disable iff (!rst_n) // [RL16]
		readStrobe && readAddr == srs_pkg::ADDR_MUTE_STAT |=> readData[15:3] == 13'h0000 && readData[1:0] == 2'h0)
		else $error("mute register reserved bits nonzero");
	AST_UNMAPPED_ZERO: assert property (@(posedge clk) disable iff (!rst_n) // [RL16]
		readStrobe && readAddr < srs_pkg::ADDR_MUTE_STAT |=> readData == 16'h0000)
		else $error("unmapped address read nonzero");
	AST_MUTE_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // [RL1]
		muteStateFlag && (hostMuteRequest || (burstAutoMuteEnable && burstSeenFlag)) |=> muteStateFlag)
		else $error("mute status dropped while cause held");
	AST_MUTE_DROP: assert property (@(posedge clk) disable iff (!rst_n) // [RL1]
		!hostMuteRequest && !(burstAutoMuteEnable && burstSeenFlag) |=> !muteStateFlag && !audioMuted)
		else $error("mute held without a cause");
	AST_BURST_CLEAR: assert property (@(posedge clk) disable iff (!rst_n) // [RL3]
		!burstSeen |=> !burstSeenFlag)
		else $error("burst flag set without bursts");
	AST_BERR_CLEAR: assert property (@(posedge clk) disable iff (!rst_n) // [RL4]
		!biphaseError |=> !bitErrorFlag)
		else $error("bit error flag set without errors");
	AST_LOCK_OUT: assert property (@(posedge clk) disable iff (!rst_n) // [RL5]
		!decoderLock |=> !receiverLockFlag)
		else $error("lock flag set while out of lock");
endmodule
`default_nettype wire

//--- test/srs_src_model.sv
// Status-bit source standing in for the incoming stream
// Assumes the bench calls send after reset is released
`timescale 1ns/1ps
`default_nettype none
module srs_src_model
(
	input  wire logic clk,
	output logic      leftBitValid,
	output logic      rightBitValid,
	output logic      chanStatusBit,
	output logic      blockStart
);
	initial {leftBitValid, rightBitValid, chanStatusBit, blockStart} = 4'h0;
	// ----------------------------
	// Frames: left bit then right bit, bit 0 marked
	// ----------------------------
	task automatic send(input logic [39:0] l, input logic [39:0] r, input int n);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk) #1;
			{leftBitValid, rightBitValid, blockStart, chanStatusBit} = {2'h2, i == 0, l[i]};
			@(posedge clk) #1;
			{leftBitValid, rightBitValid, blockStart, chanStatusBit} = {2'h1, i == 0, r[i]};
		end
		@(posedge clk) #1;
		{leftBitValid, rightBitValid, blockStart} = 3'h0;
		chanStatusBit = ~chanStatusBit;
	endtask
endmodule
`default_nettype wire

//--- test/tb.sv
// Self-checking bench for the status readout registers
// Assumes the source model feeds the status bit inputs
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk, rst_n, sel, amEn, merge, muteReq, dLock, pcm, burst, berr, strobe;
	logic [7:0]  addr;
	logic [15:0] readData;
	logic        readValid, audioMuted, activeInput, lv, rv, csb, bs;
	int          errCount, testsRun, cyc;
	logic [7:0]  ra [10] = '{8'h18, 8'h59, 8'h5A, 8'h5B, 8'h5C, 8'h5D, 8'h5E, 8'h5F, 8'h00, 8'h7F};
	srs_src_model src_u (.clk(clk), .leftBitValid(lv), .rightBitValid(rv), .chanStatusBit(csb), .blockStart(bs));
	srs_status_readout #(.MUTE_STEPS(16)) dut_u (.clk(clk), .rst_n(rst_n), .inputSourceSelect(sel),
		.burstAutoMuteEnable(amEn), .pcmLockMerge(merge), .hostMuteRequest(muteReq), .decoderLock(dLock),
		.pcmDetect(pcm), .burstSeen(burst), .biphaseError(berr), .leftBitValid(lv), .rightBitValid(rv),
		.chanStatusBit(csb), .blockStart(bs), .readStrobe(strobe), .readAddr(addr), .readData(readData),
		.readValid(readValid), .audioMuted(audioMuted), .activeInput(activeInput));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 8000)
		begin
			errCount++;
			endOfTest();
		end
	end
	// ----------------------------
	// Access tasks
	// ----------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		testsRun++;
		if (got !== exp)
		begin
			errCount++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk) #1;
		strobe = 1'b1;
		addr = a;
		@(posedge clk) #1;
		strobe = 1'b0;
		chk({15'h0000, readValid}, 16'h0001);
		chk(readData, exp);
	endtask
	task automatic mute(input logic r, input logic b, input logic e, input logic [15:0] exp);
		{muteReq, burst, amEn} = {r, b, e};
		rd(8'h18, 16'h0000);
		repeat (8) @(posedge clk);
		rd(8'h18, 16'h0000);
		repeat (10) @(posedge clk);
		rd(8'h18, exp);
		chk({15'h0000, audioMuted}, {15'h0000, exp[2]});
		{muteReq, burst} = 2'h0;
		repeat (2) @(posedge clk);
		rd(8'h18, 16'h0000);
	endtask
	task automatic cs(input logic [39:0] l, input logic [39:0] r);
		rd(8'h5A, l[15:0]);
		rd(8'h5B, l[31:16]);
		rd(8'h5C, {8'h00, l[39:32]});
		rd(8'h5D, r[15:0]);
		rd(8'h5E, r[31:16]);
		rd(8'h5F, {8'h00, r[39:32]});
	endtask
	task automatic endOfTest();
		$display("errors %0d checks %0d", errCount, testsRun);
		if (errCount == 0 && testsRun > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ----------------------------
	// Sequence
	// ----------------------------
	initial
	begin
		{rst_n, sel, amEn, merge, muteReq, dLock, pcm, burst, berr, strobe, addr} = 18'h00000;
		errCount = 0;
		testsRun = 0;
		cyc = 0;
		repeat (6) @(posedge clk);
		#1;
		rst_n = 1'b1;
		foreach (ra[k]) rd(ra[k], 16'h0000);
		chk({15'h0000, activeInput}, 16'h0000);
		for (int i = 0; i < 32; i++)
		begin
			{merge, pcm, dLock, berr, burst} = i[4:0];
			rd(8'h59, {13'h0000, i[0], i[1], i[2] & (i[3] | !i[4])});
		end
		{merge, pcm, dLock, berr, burst} = 5'h00;
		sel = 1'b1;
		rd(8'h59, 16'h0008);
		chk({15'h0000, activeInput}, 16'h0001);
		mute(1'b1, 1'b0, 1'b0, 16'h0004);
		mute(1'b0, 1'b1, 1'b1, 16'h0004);
		mute(1'b0, 1'b1, 1'b0, 16'h0000);
		src_u.send(40'h9C_F0E1_D2C3, 40'h3A_5A69_8796, 40);
		cs(40'h9C_F0E1_D2C3, 40'h3A_5A69_8796);
		cs(40'h9C_F0E1_D2C3, 40'h3A_5A69_8796);
		src_u.send(40'h63_0F1E_2D3C, 40'hC5_A596_7869, 12);
		cs(40'h9C_F0E1_D2C3, 40'h3A_5A69_8796);
		src_u.send(40'h63_0F1E_2D3C, 40'hC5_A596_7869, 40);
		cs(40'h63_0F1E_2D3C, 40'hC5_A596_7869);
		endOfTest();
	end
endmodule
`default_nettype wire
